// ---- src/sbs_defs.svh ----
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define SBS_ADDR_W 20
`define SBS_LANES 2
`define SBS_LANE_W 9
`define SBS_OFS_W 2
`define SBS_OFS_ZERO 2'h0
`define SBS_OFS_ONE 2'h1

`endif

// ---- src/sbs_pkg.sv ----
package sbs_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    // Burst order select
    typedef enum logic {
        SBS_ORDER_INTERLEAVED = 1'b0,
        SBS_ORDER_LINEAR = 1'b1
    } sbs_order_e;

    // Selection state
    typedef enum logic {
        SBS_DESEL = 1'b0,
        SBS_SEL = 1'b1
    } sbs_state_e;

    // Kind of bus cycle decoded on one edge
    typedef enum logic [1:0] {
        SBS_CYC_IDLE = 2'b00,
        SBS_CYC_READ = 2'b01,
        SBS_CYC_WRITE = 2'b10,
        SBS_CYC_DESEL = 2'b11
    } sbs_cycle_e;

endpackage : sbs_pkg

// ---- src/sbs_mem_if.sv ----
`timescale 1ns/1ps

// Array access channel between cycle logic and storage
interface sbs_mem_if #(
    parameter int ADDR_W = 20,
    parameter int LANES = 2,
    parameter int LANE_W = 9
);
    logic [ADDR_W-1:0] addr;
    logic rd_en;
    logic [LANES-1:0] wr_lanes;
    logic [LANES*LANE_W-1:0] wdata;
    logic [LANES*LANE_W-1:0] rdata;

    modport ctrl (output addr, output rd_en, output wr_lanes, output wdata, input rdata);
    modport store (input addr, input rd_en, input wr_lanes, input wdata, output rdata);
endinterface : sbs_mem_if

// ---- src/sbs_store.sv ----
`timescale 1ns/1ps

// Byte-lane storage array with registered read
module sbs_store #(
    parameter int ADDR_W = 20,
    parameter int LANES = 2,
    parameter int LANE_W = 9
) (
    input wire logic clk,
    sbs_mem_if.store mem
);
    logic [LANE_W-1:0] cells [0:(2**ADDR_W)-1][0:LANES-1];
    logic [LANES*LANE_W-1:0] rdata_ff;

    // Per-lane write
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (mem.wr_lanes[i])
            begin
                cells[mem.addr][i] <= mem.wdata[i*LANE_W +: LANE_W];
            end
        end
    end

    // Registered read, first pipeline stage
    always_ff @(posedge clk)
    begin
        if (mem.rd_en)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                rdata_ff[i*LANE_W +: LANE_W] <= cells[mem.addr][i];
            end
        end
    end

    assign mem.rdata = rdata_ff;

endmodule : sbs_store

// ---- src/sbs_sram.sv ----
`timescale 1ns/1ps
`include "sbs_defs.svh"

// Functional notes
// RL1: Byte-lane write low masks output enable
// RL2: Controller strobe plus write enables: write
// RL3: Processor strobe or byte-write high: read
// RL4: Load address only when selected and strobed
// RL5: Master gives valid enables on strobed edges
// RL6: Selected only when all three enables true
// RL7: No drive from idle before next edge
// RL8: Outputs off within one cycle of deselect
// RL9: Later beats use burst counter address
// RL10: Advance high keeps write at loaded address
// RL11: Master keeps output enable high for writes
// RL12: Global write or all lanes writes everything
// RL13: Outputs stay off after write until new cycle
// RL14: Either strobe may start back-to-back reads
// RL15: Two-bit counter wraps, linear or interleaved
module sbs_sram #(
    parameter int ADDR_W = `SBS_ADDR_W,
    parameter int LANES = `SBS_LANES,
    parameter int LANE_W = `SBS_LANE_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chip_select_n,
    input wire logic second_select_n,
    input wire logic third_select,
    input wire logic controller_addr_strobe_n,
    input wire logic processor_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [LANES-1:0] byte_lane_write_n,
    input wire logic output_enable_n,
    input wire sbs_pkg::sbs_order_e burst_order,
    input wire logic [LANES*LANE_W-1:0] dq_in,
    output logic [LANES*LANE_W-1:0] dq_out,
    output logic dq_oe_n
);
    import sbs_pkg::*;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Burst offset from start offset and beat count
    function automatic logic [`SBS_OFS_W-1:0] burst_ofs(
        input logic [`SBS_OFS_W-1:0] start,
        input logic [`SBS_OFS_W-1:0] beat,
        input sbs_order_e order
    );
        if (order == SBS_ORDER_LINEAR)
        begin
            burst_ofs = start + beat; // wraps in the group [RL15]
        end
        else
        begin
            burst_ofs = start ^ beat; // [RL15]
        end
    endfunction : burst_ofs

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    sbs_mem_if #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) mem ();

    sbs_state_e state_ff;
    sbs_state_e nxt_state;
    sbs_cycle_e cyc;
    logic [ADDR_W-1:0] base_ff;
    logic [`SBS_OFS_W-1:0] beat_ff;
    logic [`SBS_OFS_W-1:0] nxt_beat;
    logic rd_pend_ff;
    logic rd_valid_ff;
    logic wr_park_ff;
    logic [LANES*LANE_W-1:0] dq_out_ff;
    logic selected;
    logic strobe;
    logic start;
    logic any_lane;
    logic wr_req;
    logic [LANES-1:0] lanes;
    logic [ADDR_W-1:0] acc_addr;

    // ------------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------------
    // Enables, strobes and write qualifiers
    assign selected = ~chip_select_n & ~second_select_n & third_select; // [RL6]
    assign strobe = ~controller_addr_strobe_n | ~processor_addr_strobe_n;
    assign start = strobe & selected; // [RL4] [RL5]
    assign any_lane = |(~byte_lane_write_n);
    assign wr_req = ~global_write_n | (~byte_write_enable_n & any_lane); // [RL2]

    // Lanes written on a write cycle
    always_comb
    begin
        if (!global_write_n)
        begin
            lanes = {LANES{1'b1}}; // [RL12]
        end
        else
        begin
            lanes = ~byte_lane_write_n; // all low writes every lane [RL12]
        end
    end

    // Classify this edge
    always_comb
    begin
        cyc = SBS_CYC_IDLE;
        nxt_state = state_ff;
        nxt_beat = beat_ff;
        if (start)
        begin
            nxt_state = SBS_SEL;
            nxt_beat = `SBS_OFS_ZERO;
            if (!processor_addr_strobe_n)
            begin
                cyc = SBS_CYC_READ; // [RL3] [RL14]
            end
            else if (wr_req)
            begin
                cyc = SBS_CYC_WRITE; // [RL2]
            end
            else
            begin
                cyc = SBS_CYC_READ; // [RL3] [RL14]
            end
        end
        else if (strobe)
        begin
            nxt_state = SBS_DESEL;
            cyc = SBS_CYC_DESEL;
        end
        else
        begin
            case (state_ff)
                SBS_SEL:
                begin
                    if (!burst_advance_n)
                    begin
                        nxt_beat = beat_ff + `SBS_OFS_ONE; // [RL9]
                    end
                    if (wr_req)
                    begin
                        cyc = SBS_CYC_WRITE; // [RL10]
                    end
                    else if (wr_park_ff && burst_advance_n)
                    begin
                        cyc = SBS_CYC_IDLE; // parked after a write [RL13]
                    end
                    else
                    begin
                        cyc = SBS_CYC_READ;
                    end
                end
                default:
                begin
                    cyc = SBS_CYC_IDLE;
                end
            endcase
        end
    end

    // Address of this access
    always_comb
    begin
        if (start)
        begin
            acc_addr = addr; // [RL4]
        end
        else
        begin
            acc_addr = {base_ff[ADDR_W-1:`SBS_OFS_W],
                        burst_ofs(base_ff[`SBS_OFS_W-1:0], nxt_beat, burst_order)}; // [RL9]
        end
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    // Selection state and burst counter
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= SBS_DESEL;
            beat_ff <= `SBS_OFS_ZERO;
        end
        else
        begin
            state_ff <= nxt_state;
            beat_ff <= nxt_beat;
        end
    end

    // Loaded start address
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            base_ff <= '0;
        end
        else if (start)
        begin
            base_ff <= addr; // [RL4]
        end
    end

    // Read pipeline flags
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_pend_ff <= 1'b0;
            rd_valid_ff <= 1'b0;
        end
        else
        begin
            rd_pend_ff <= (cyc == SBS_CYC_READ); // writes leave it clear [RL13]
            rd_valid_ff <= rd_pend_ff; // set only after an edge [RL7] [RL8]
        end
    end

    // Write parks the outputs until a strobe or advance starts a cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_park_ff <= 1'b0;
        end
        else if (cyc == SBS_CYC_WRITE)
        begin
            wr_park_ff <= 1'b1; // [RL13]
        end
        else if (cyc != SBS_CYC_IDLE)
        begin
            wr_park_ff <= 1'b0; // [RL13]
        end
    end

    // Output data register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dq_out_ff <= '0;
        end
        else if (rd_pend_ff)
        begin
            dq_out_ff <= mem.rdata;
        end
    end

    // ------------------------------------------------------------------------
    // Storage and pins
    // ------------------------------------------------------------------------
    // Array requests
    assign mem.addr = acc_addr;
    assign mem.rd_en = (cyc == SBS_CYC_READ);
    assign mem.wr_lanes = (cyc == SBS_CYC_WRITE) ? lanes : '0;
    assign mem.wdata = dq_in;

    sbs_store #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) u_store (
        .clk (clk),
        .mem (mem.store)
    );

    // Drive only valid read data, never against a lane write
    assign dq_oe_n = ~(rd_valid_ff & ~output_enable_n & ~any_lane); // [RL1] [RL11]
    assign dq_out = dq_out_ff;

endmodule : sbs_sram

// ---- bench/sbs_sram_chk.sv ----
`timescale 1ns/1ps
// Host port checker
module sbs_sram_chk #(
    parameter int LANES = 2,
    parameter int LANE_W = 9
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic chip_select_n,
    input wire logic second_select_n,
    input wire logic third_select,
    input wire logic controller_addr_strobe_n,
    input wire logic processor_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [LANES-1:0] byte_lane_write_n,
    input wire logic output_enable_n,
    input wire logic [LANES*LANE_W-1:0] dq_out,
    input wire logic dq_oe_n
);
    logic sel, strb, wreq, wr_go, rd_go, desel, rd_any, wr_any, sel_ff;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Cycle decode
    assign sel = !chip_select_n && !second_select_n && third_select;
    assign strb = !controller_addr_strobe_n || !processor_addr_strobe_n;
    assign wreq = !global_write_n || (!byte_write_enable_n && !(&byte_lane_write_n));
    assign wr_go = sel && processor_addr_strobe_n && !controller_addr_strobe_n && wreq;
    assign rd_go = sel && strb && !wr_go;
    assign desel = strb && !sel;
    assign rd_any = rd_go || (sel_ff && !strb && !wreq);
    assign wr_any = wr_go || (sel_ff && !strb && wreq);
    // Selection state
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            sel_ff <= 1'b0;
        else if (strb)
            sel_ff <= sel;
    end
    property p_lane_oe;
        !(&byte_lane_write_n) |-> dq_oe_n;
    endproperty
    a_lane_oe: assert property (p_lane_oe) else $error("drive during lane write");
    property p_oe_off;
        output_enable_n |-> dq_oe_n;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive with oe high");
    property p_rd_lat;
        rd_go ##2 (!output_enable_n && &byte_lane_write_n) |-> !dq_oe_n;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read not driven");
    property p_no_early;
        rd_go && !sel_ff && !$past(sel_ff) |-> dq_oe_n ##1 dq_oe_n;
    endproperty
    a_no_early: assert property (p_no_early) else $error("early drive");
    property p_desel;
        desel |-> ##2 dq_oe_n;
    endproperty
    a_desel: assert property (p_desel) else $error("drive after deselect");
    property p_stay_off;
        desel ##1 !strb [*3] |-> dq_oe_n;
    endproperty
    a_stay_off: assert property (p_stay_off) else $error("start without strobe");
    property p_wr_hiz;
        wr_any ##1 (!strb && burst_advance_n && !wreq) [*4] |-> dq_oe_n;
    endproperty
    a_wr_hiz: assert property (p_wr_hiz) else $error("drive after write");
    property p_dq_hold;
        $changed(dq_out) |-> $past(rd_any, 2);
    endproperty
    a_dq_hold: assert property (p_dq_hold) else $error("data moved without read");
endmodule : sbs_sram_chk

bind sbs_sram sbs_sram_chk #(.LANES(LANES), .LANE_W(LANE_W)) sbs_sram_chk_i (.*);

// ---- bench/sbs_master.sv ----
`timescale 1ns/1ps
// Bus master model on the host port
module sbs_master (
    input wire logic clk,
    input wire logic [17:0] dq_out,
    input wire logic dq_oe_n,
    output logic [5:0] addr,
    output logic chip_select_n,
    output logic second_select_n,
    output logic third_select,
    output logic controller_addr_strobe_n,
    output logic processor_addr_strobe_n,
    output logic burst_advance_n,
    output logic global_write_n,
    output logic byte_write_enable_n,
    output logic [1:0] byte_lane_write_n,
    output logic output_enable_n,
    output sbs_pkg::sbs_order_e burst_order,
    output logic [17:0] dq_in
);
    import sbs_pkg::*;
    logic [17:0] rdq [4];
    // Quiet bus at start
    initial
    begin
        {chip_select_n, second_select_n, third_select} = 3'b110;
        {controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n} = 3'b111;
        {global_write_n, byte_write_enable_n, byte_lane_write_n} = 4'hF;
        output_enable_n = 1'b1;
        addr = 6'h00;
        dq_in = 18'h00000;
        burst_order = SBS_ORDER_LINEAR;
    end
    // One edge; enables always valid
    task automatic drv(input logic [2:0] e, input logic [1:0] s, input logic v,
                       input logic [3:0] w, input logic [17:0] d);
        @(negedge clk);
        {chip_select_n, second_select_n, third_select} = e;
        {controller_addr_strobe_n, processor_addr_strobe_n} = s;
        burst_advance_n = v;
        {global_write_n, byte_write_enable_n, byte_lane_write_n} = w;
        dq_in = d;
    endtask : drv
    // Deselect, then advance while unselected
    task automatic stop();
        drv(3'b110, 2'b01, 1'b1, 4'hF, ~dq_in);
        repeat (3) drv(3'b110, 2'b11, 1'b0, 4'hF, ~dq_in);
    endtask : stop
    // Write burst; oe held high on the write beats, low on the idle edges after
    task automatic wr(input logic [2:0] e, input logic [5:0] a, input int n,
                      input logic v, input logic [3:0] w, input logic [17:0] d);
        output_enable_n = 1'b1;
        addr = a;
        drv(e, 2'b01, 1'b1, w, d);
        for (int i = 1; i < n; i++)
        begin
            drv(e, 2'b11, v, w, d + 18'(i));
            addr = ~a;
        end
        drv(e, 2'b11, 1'b1, 4'hF, ~dq_in);
        output_enable_n = 1'b0;
        repeat (3) drv(e, 2'b11, 1'b1, 4'hF, ~dq_in);
        stop();
    endtask : wr
    // Read burst by either strobe
    task automatic rd(input logic [5:0] a, input int n, input logic [1:0] s);
        output_enable_n = 1'b0;
        addr = a;
        drv(3'b001, s, 1'b1, 4'hF, ~dq_in);
        for (int k = 1; k < n + 2; k++)
        begin
            drv(3'b001, 2'b11, k >= n, 4'hF, ~dq_in);
            addr = ~a;
            #1;
            // Released bus reads back inverted
            if (k >= 2)
                rdq[k - 2] = dq_oe_n ? ~dq_out : dq_out;
        end
        stop();
    endtask : rd
endmodule : sbs_master

// ---- bench/sync_burst_sram_bus_cycles_test.sv ----
`timescale 1ns/1ps
// Bench top for the host port
module sync_burst_sram_bus_cycles_test;
    import sbs_pkg::*;
    logic clk, rstn, chip_select_n, second_select_n, third_select, burst_advance_n;
    logic controller_addr_strobe_n, processor_addr_strobe_n, global_write_n;
    logic byte_write_enable_n, output_enable_n, dq_oe_n;
    logic [1:0] byte_lane_write_n;
    logic [5:0] addr;
    logic [17:0] dq_in, dq_out;
    sbs_order_e burst_order;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    sbs_sram #(.ADDR_W(6)) sbs_sram_i (.*);
    sbs_master sbs_master_i (.*);
    // Clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            summarize();
        end
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Linear burst written from offset 1, read from offset 0
    task automatic t_linear();
        sbs_master_i.burst_order = SBS_ORDER_LINEAR;
        sbs_master_i.wr(3'b001, 6'h05, 4, 1'b0, 4'b1000, 18'h00100);
        sbs_master_i.rd(6'h04, 4, 2'b10);
        for (int i = 0; i < 4; i++)
            check(sbs_master_i.rdq[i], 18'h00100 + 18'((i + 3) % 4));
    endtask : t_linear
    // Interleaved global write, read by controller strobe
    task automatic t_inter();
        sbs_master_i.burst_order = SBS_ORDER_INTERLEAVED;
        sbs_master_i.wr(3'b001, 6'h09, 4, 1'b0, 4'b0011, 18'h00200);
        sbs_master_i.rd(6'h0A, 4, 2'b01);
        for (int i = 0; i < 4; i++)
            check(sbs_master_i.rdq[i], 18'h00203 - 18'(i));
    endtask : t_inter
    // Single lane rewritten twice at one address
    task automatic t_lane();
        sbs_master_i.wr(3'b001, 6'h10, 2, 1'b0, 4'b0011, 18'h2AAAA);
        sbs_master_i.wr(3'b001, 6'h10, 2, 1'b1, 4'b1010, 18'h00000);
        sbs_master_i.rd(6'h10, 2, 2'b10);
        check(sbs_master_i.rdq[0], (18'h2AAAA & 18'h3FE00) | 18'h00001);
        check(sbs_master_i.rdq[1], 18'h2AAAB);
    endtask : t_lane
    // Each enable false in turn blocks a write
    task automatic t_unsel();
        logic [2:0] bad [3] = '{3'b101, 3'b011, 3'b000};
        for (int i = 0; i < 3; i++)
        begin
            sbs_master_i.wr(bad[i], 6'h11, 1, 1'b1, 4'b0011, 18'h00000);
            sbs_master_i.rd(6'h11, 1, 2'b10);
            check(sbs_master_i.rdq[0], 18'h2AAAB);
        end
    endtask : t_unsel
    // Main sequence
    initial
    begin
        rstn = 1'b0;
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        t_linear();
        t_inter();
        t_lane();
        t_unsel();
        summarize();
    end
endmodule : sync_burst_sram_bus_cycles_test
